// file: logic/coc_top.sv
// Cam operation error checker: APB registers, cam table store, start checks
// and per-control-cycle slave motion checks for one cam axis at a time.
// Assumes motion inputs come from logic on ref_clk, valid on each cycle tick.
// Functional notes
// - A slave offset that does not fit a signed 32-bit value raises the offset error.
// - Starting a cam while the table is being rewritten raises the busy error.
// - Table phases that are not strictly ascending raise the data error.
// - A first entry with nonzero phase or displacement raises the data error.
// - A phase outside 0 to 7FFFFFFF hex raises the data error.
// - A table with fewer than two entries raises the data error.
// - A master gap that reaches 31 bits in command units raises the sync direction error.
// - A slave target outside the signed 32-bit pulse range raises the overflow error.
// - With all axes linear, per-cycle movement outside signed 32 bits raises overflow.
// - Starting with a nonzero direction selection word raises its range error.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module coc_top #(
    parameter int CYC_CLKS = coc_pkg::CYC_CLKS,
    parameter int TBL_DEPTH = coc_pkg::TBL_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [63:0] mot_target_pls,
    input wire logic [63:0] mot_move_pls,
    input wire logic [63:0] mot_move_cmd,
    input wire logic [63:0] mot_gap_cmd,
    input wire logic mot_all_linear,
    output logic cam_run,
    output logic cyc_tick,
    output logic [2:0] err_code,
    output logic [coc_pkg::AXIS_W-1:0] err_axis,
    output logic irq
);
    import coc_pkg::*;

    localparam int IDX_W = $clog2(TBL_DEPTH);

    // True when x fits a signed value of n bits
    function automatic logic fits(input logic [63:0] x, input int n);
        logic r;
        r = 1'b1;
        for (int i = 0; i < 64; i++)
        begin
            if (i >= n - 1 && x[i] != x[63])
                r = 1'b0;
        end
        return r;
    endfunction : fits

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'b00 && a <= OFS_IRQ_MSK;
    endfunction : mapped

    logic [31:0] ph_mem [TBL_DEPTH];
    logic [31:0] dp_mem [TBL_DEPTH];

    coc_state_t st_r, st_nxt;
    logic [2:0] err_r, err_nxt;
    logic [AXIS_W-1:0] axis_r, axis_nxt, eaxis_r, eaxis_nxt;
    logic [63:0] sofs_r, sofs_nxt;
    logic [31:0] dirsel_r, dirsel_nxt, prev_r, prev_nxt;
    logic [IDX_W:0] len_r, len_nxt;
    logic [IDX_W-1:0] tidx_r, tidx_nxt, widx_r, widx_nxt;
    logic xfer_r, xfer_nxt;
    logic [N_EVT-1:0] ist_r, ist_nxt, msk_r, msk_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic tick_r, tick_nxt, run_r, run_nxt, irq_r, irq_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic rdy_r, rdy_nxt, serr_r, serr_nxt;
    logic [2:0] det;
    logic acc, wr, start, erst, stop, tbl_wr_ph, tbl_wr_dp, bad;
    logic [31:0] ph, dp;

    assign ph = ph_mem[widx_r];
    assign dp = dp_mem[widx_r];
    // Writes take effect only at the access edge with pready high
    assign acc = psel && penable && rdy_r;
    assign wr = acc && pwrite && mapped(paddr);
    assign tbl_wr_ph = wr && paddr == OFS_TBL_PH;
    assign tbl_wr_dp = wr && paddr == OFS_TBL_DP;

    always_ff @(posedge ref_clk)
    begin
        if (tbl_wr_ph)
            ph_mem[tidx_r] <= pwdata;
        if (tbl_wr_dp)
            dp_mem[tidx_r] <= pwdata;
    end

    always_comb
    begin
        st_nxt = st_r;
        err_nxt = err_r;
        axis_nxt = axis_r;
        eaxis_nxt = eaxis_r;
        sofs_nxt = sofs_r;
        dirsel_nxt = dirsel_r;
        prev_nxt = prev_r;
        len_nxt = len_r;
        tidx_nxt = tidx_r;
        widx_nxt = widx_r;
        xfer_nxt = xfer_r;
        msk_nxt = msk_r;
        ist_nxt = ist_r;
        det = ERR_NONE;
        bad = 1'b0;
        start = 1'b0;
        erst = 1'b0;
        stop = 1'b0;
        // Register writes
        if (wr)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    start = pwdata[CTRL_START];
                    erst = pwdata[CTRL_ERST];
                    stop = pwdata[CTRL_STOP];
                    if (st_r == ST_IDLE)
                        axis_nxt = pwdata[CTRL_AXIS_LSB +: AXIS_W];
                end
                OFS_SOFS_LO: sofs_nxt[31:0] = pwdata;
                OFS_SOFS_HI: sofs_nxt[63:32] = pwdata;
                OFS_DIRSEL: dirsel_nxt = pwdata;
                OFS_TBL_LEN: len_nxt = pwdata[IDX_W:0];
                OFS_TBL_IDX: tidx_nxt = pwdata[IDX_W-1:0];
                OFS_TBL_DP: tidx_nxt = IDX_W'(tidx_r + 1'b1);
                OFS_XFER: xfer_nxt = pwdata[0];
                OFS_IRQ_ST: ist_nxt = ist_r & ~pwdata[N_EVT-1:0];
                OFS_IRQ_MSK: msk_nxt = pwdata[N_EVT-1:0];
                default: ;
            endcase
        end
        // Checks; a latched error refuses new starts until reset
        case (st_r)
            ST_IDLE:
            begin
                if (start && err_r == ERR_NONE)
                begin
                    if (xfer_r)
                        det = ERR_BUSY;
                    else if (dirsel_r != 32'h0000_0000)
                        det = ERR_DIRSEL;
                    else if (!fits(sofs_r, OFS_BITS))
                        det = ERR_OFS;
                    else if (len_r < 2 || len_r > TBL_DEPTH)
                        det = ERR_DATA;
                    else
                    begin
                        st_nxt = ST_WALK;
                        widx_nxt = '0;
                    end
                end
            end
            ST_WALK:
            begin
                bad = ph > PHASE_MAX;
                if (widx_r == '0)
                    bad = bad || ph != 32'h0000_0000 || dp != 32'h0000_0000;
                else if (ph <= prev_r)
                    bad = 1'b1;
                prev_nxt = ph;
                if (xfer_r)
                    det = ERR_BUSY;
                else if (bad)
                    det = ERR_DATA;
                else if ({1'b0, widx_r} == len_r - 1'b1)
                    st_nxt = ST_RUN;
                else
                    widx_nxt = IDX_W'(widx_r + 1'b1);
            end
            ST_RUN:
            begin
                if (stop || erst)
                    st_nxt = ST_IDLE;
                else if (tick_r)
                begin
                    if (!fits(mot_target_pls, POS_BITS))
                        det = ERR_OVF;
                    else if (!fits(mot_move_pls, MOVE_PLS_BITS))
                        det = ERR_OVF;
                    else if (mot_all_linear && !fits(mot_move_cmd, MOVE_CMD_BITS))
                        det = ERR_OVF;
                    else if (!fits(mot_gap_cmd, GAP_BITS))
                        det = ERR_SYNC;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        // New error beats a same-cycle reset
        if (det != ERR_NONE)
        begin
            err_nxt = det;
            // Axis written with the start itself must be the one reported
            eaxis_nxt = axis_nxt;
            st_nxt = ST_IDLE;
            ist_nxt[det - 3'd1] = 1'b1;
        end
        else if (erst)
            err_nxt = ERR_NONE;
        // Control cycle divider
        tick_nxt = 1'b0;
        cnt_nxt = CNT_W'(cnt_r + 1'b1);
        if (cnt_r == CNT_W'(CYC_CLKS - 1))
        begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end
        run_nxt = st_nxt == ST_RUN;
        irq_nxt = |(ist_nxt & msk_nxt);
        // APB: data registered in setup, answered in the first access cycle
        rdy_nxt = psel && !penable;
        serr_nxt = psel && !penable && !mapped(paddr);
        rd_nxt = rd_r;
        if (psel && !penable)
        begin
            case (paddr)
                OFS_CTRL: rd_nxt = 32'(axis_r) << CTRL_AXIS_LSB;
                OFS_SOFS_LO: rd_nxt = sofs_r[31:0];
                OFS_SOFS_HI: rd_nxt = sofs_r[63:32];
                OFS_DIRSEL: rd_nxt = dirsel_r;
                OFS_TBL_LEN: rd_nxt = 32'(len_r);
                OFS_TBL_IDX: rd_nxt = 32'(tidx_r);
                OFS_TBL_PH: rd_nxt = ph_mem[tidx_r];
                OFS_TBL_DP: rd_nxt = dp_mem[tidx_r];
                OFS_XFER: rd_nxt = 32'(xfer_r);
                OFS_STATUS: rd_nxt = (32'(err_r) << STS_ERR_LSB) | (32'(eaxis_r)
                    << STS_AXIS_LSB) | (32'(st_r) << STS_STATE_LSB);
                OFS_IRQ_ST: rd_nxt = 32'(ist_r);
                OFS_IRQ_MSK: rd_nxt = 32'(msk_r);
                default: rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= ST_IDLE;
            err_r <= ERR_NONE;
            axis_r <= '0;
            eaxis_r <= '0;
            sofs_r <= '0;
            dirsel_r <= '0;
            prev_r <= '0;
            len_r <= '0;
            tidx_r <= '0;
            widx_r <= '0;
            xfer_r <= 1'b0;
            ist_r <= '0;
            msk_r <= '0;
            cnt_r <= '0;
            tick_r <= 1'b0;
            run_r <= 1'b0;
            irq_r <= 1'b0;
            rd_r <= '0;
            rdy_r <= 1'b0;
            serr_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            err_r <= err_nxt;
            axis_r <= axis_nxt;
            eaxis_r <= eaxis_nxt;
            sofs_r <= sofs_nxt;
            dirsel_r <= dirsel_nxt;
            prev_r <= prev_nxt;
            len_r <= len_nxt;
            tidx_r <= tidx_nxt;
            widx_r <= widx_nxt;
            xfer_r <= xfer_nxt;
            ist_r <= ist_nxt;
            msk_r <= msk_nxt;
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
            run_r <= run_nxt;
            irq_r <= irq_nxt;
            rd_r <= rd_nxt;
            rdy_r <= rdy_nxt;
            serr_r <= serr_nxt;
        end
    end

    assign prdata = rd_r;
    assign pready = rdy_r;
    assign pslverr = serr_r;
    assign cam_run = run_r;
    assign cyc_tick = tick_r;
    assign err_code = err_r;
    assign err_axis = eaxis_r;
    assign irq = irq_r;
endmodule : coc_top

// file: logic/coc_pkg.sv
// Constants, register map and types of the cam operation error checker.
// Assumes a 10 MHz ref_clk and a 32-bit APB register bus.
package coc_pkg;
    localparam int CLK_NS = 100;
    localparam int CYC_US = 1000;
    localparam int CYC_CLKS = (CYC_US * 1000) / CLK_NS;
    localparam int TBL_DEPTH = 64;
    localparam int AXIS_W = 4;
    localparam int CNT_W = 16;
    // Byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SOFS_LO = 8'h04;
    localparam logic [7:0] OFS_SOFS_HI = 8'h08;
    localparam logic [7:0] OFS_DIRSEL = 8'h0C;
    localparam logic [7:0] OFS_TBL_LEN = 8'h10;
    localparam logic [7:0] OFS_TBL_IDX = 8'h14;
    localparam logic [7:0] OFS_TBL_PH = 8'h18;
    localparam logic [7:0] OFS_TBL_DP = 8'h1C;
    localparam logic [7:0] OFS_XFER = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_ST = 8'h28;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h2C;
    // CTRL fields
    localparam int CTRL_START = 0;
    localparam int CTRL_ERST = 1;
    localparam int CTRL_STOP = 2;
    localparam int CTRL_AXIS_LSB = 4;
    // STATUS fields
    localparam int STS_ERR_LSB = 0;
    localparam int STS_AXIS_LSB = 4;
    localparam int STS_STATE_LSB = 8;
    // Limits
    localparam logic [31:0] PHASE_MAX = 32'h7FFF_FFFF;
    localparam int OFS_BITS = 32;
    localparam int GAP_BITS = 31;
    localparam int MOVE_PLS_BITS = 30;
    localparam int MOVE_CMD_BITS = 32;
    localparam int POS_BITS = 32;
    localparam int N_EVT = 6;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WALK = 2'b01,
        ST_RUN = 2'b10
    } coc_state_t;
    typedef enum logic [2:0] {
        ERR_NONE = 3'b000,
        ERR_OFS = 3'b001,
        ERR_BUSY = 3'b010,
        ERR_DATA = 3'b011,
        ERR_SYNC = 3'b100,
        ERR_OVF = 3'b101,
        ERR_DIRSEL = 3'b110
    } coc_err_t;
endpackage : coc_pkg

// file: bench/coc_assertions.sv
// Port-level properties of the cam operation error checker.
// Assumes binding onto coc_top; one ref_clk domain, async rst_n.
`timescale 1ns/1ns
module coc_assertions #(
    parameter int CYC_CLKS = 10,
    parameter int TBL_DEPTH = 64
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [63:0] mot_target_pls,
    input wire logic [63:0] mot_move_pls,
    input wire logic [63:0] mot_move_cmd,
    input wire logic [63:0] mot_gap_cmd,
    input wire logic mot_all_linear,
    input wire logic cam_run,
    input wire logic cyc_tick,
    input wire logic [2:0] err_code,
    input wire logic [coc_pkg::AXIS_W-1:0] err_axis
);
    import coc_pkg::*;
    logic t_ok, m_ok, c_ok, g_ok, chk, erst;
    // Sign-extension test: the value fits when all upper bits agree
    assign t_ok = (&mot_target_pls[63:31]) | (~|mot_target_pls[63:31]);
    assign m_ok = (&mot_move_pls[63:29]) | (~|mot_move_pls[63:29]);
    assign c_ok = !mot_all_linear | (&mot_move_cmd[63:31]) | (~|mot_move_cmd[63:31]);
    assign g_ok = (&mot_gap_cmd[63:30]) | (~|mot_gap_cmd[63:30]);
    assign chk = cyc_tick & cam_run;
    assign erst = psel & penable & pready & pwrite & (paddr == OFS_CTRL) & pwdata[CTRL_ERST];
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    AST_TGT: assert property (chk && !t_ok |=> err_code == ERR_OVF ##1 !cam_run [*2])
        else $error("target overflow missed");
    AST_MOVE: assert property (chk && t_ok && !m_ok |=> err_code == ERR_OVF)
        else $error("pulse move overflow missed");
    AST_CMD: assert property (chk && t_ok && m_ok && !c_ok |=> err_code == ERR_OVF)
        else $error("command move overflow missed");
    AST_SYNC: assert property (chk && t_ok && m_ok && c_ok && !g_ok |=> err_code == ERR_SYNC)
        else $error("sync direction missed");
    AST_LATCH: assert property (err_code != ERR_NONE && !erst |=> $stable(err_code) && $stable(err_axis))
        else $error("error not held");
    AST_CLR: assert property (erst && err_code != ERR_NONE |=> err_code == ERR_NONE)
        else $error("error reset ignored");
    AST_NORUN: assert property ($rose(cam_run) |-> err_code == ERR_NONE)
        else $error("run with error");
    AST_SLV: assert property (psel && !penable && paddr > 8'h2C |=> pready && pslverr)
        else $error("unmapped access accepted");
    COV_RUN: cover property ($rose(cam_run));
    COV_OVF: cover property (err_code == ERR_OVF);
    COV_DATA: cover property (err_code == ERR_DATA);
endmodule : coc_assertions
bind coc_top coc_assertions #(.CYC_CLKS(CYC_CLKS), .TBL_DEPTH(TBL_DEPTH)) u_coc_assertions (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .mot_target_pls, .mot_move_pls, .mot_move_cmd, .mot_gap_cmd, .mot_all_linear,
    .cam_run, .cyc_tick, .err_code, .err_axis);

// file: bench/coc_host_model.sv
// Host controller model: APB master writing the command words.
// Assumes nothing about wait states; holds each request until pready.
`timescale 1ns/1ns
module coc_host_model (
    input wire logic ref_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        // Settled values at mid-cycle are those the next rising edge samples
        @(negedge ref_clk);
        while (pready !== 1'h1)
            @(negedge ref_clk);
        q = prdata;
        e = pslverr;
        @(posedge ref_clk);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : xfer
endmodule : coc_host_model

// file: bench/test_cam_operation_error_checker.sv
// Bench of the cam operation error checker: table, start and run errors.
// Assumes the host model for APB and a 16-clock control cycle.
`timescale 1ns/1ns
module test_cam_operation_error_checker;
    import coc_pkg::*;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, cam_run, cyc_tick, irq, e;
    logic mot_all_linear;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [63:0] mot_target_pls, mot_move_pls, mot_move_cmd, mot_gap_cmd;
    logic [2:0] err_code;
    logic [AXIS_W-1:0] err_axis;
    logic [63:0] lim [4] = '{64'h8000_0000, 64'h2000_0000, 64'h8000_0000, 64'h4000_0000};
    int num_errors = 0;
    int n_checks = 0;
    coc_top #(.CYC_CLKS(16), .TBL_DEPTH(TBL_DEPTH)) u_coc_top (.ref_clk, .rst_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mot_target_pls,
        .mot_move_pls, .mot_move_cmd, .mot_gap_cmd, .mot_all_linear, .cam_run, .cyc_tick,
        .err_code, .err_axis, .irq);
    coc_host_model u_host (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'h1, a, d, q, e);
    endtask : wr
    task automatic ent(input logic [31:0] i, input logic [31:0] p, input logic [31:0] d);
        wr(OFS_TBL_IDX, i);
        wr(OFS_TBL_PH, p);
        wr(OFS_TBL_DP, d);
    endtask : ent
    task automatic go(input logic [3:0] ax, input logic [2:0] ec);
        wr(OFS_CTRL, {24'h00_0000, ax, 4'h1});
        for (int i = 0; i < 200 && !cam_run && err_code === ERR_NONE; i++)
            @(negedge ref_clk);
        chk(32'(err_code), 32'(ec));
        if (ec != ERR_NONE)
            chk(32'(err_axis), 32'(ax));
    endtask : go
    task automatic clr;
        wr(OFS_CTRL, 32'h0000_0002);
        @(negedge ref_clk);
        chk(32'(err_code), 32'h0);
    endtask : clr
    task automatic put(input int k, input logic [63:0] v);
        @(posedge ref_clk);
        mot_all_linear <= (k == 2);
        case (k)
            0: mot_target_pls <= v;
            1: mot_move_pls <= v;
            2: mot_move_cmd <= v;
            default: mot_gap_cmd <= v;
        endcase
    endtask : put
    task automatic t_data;
        for (int k = 0; k < 4; k++)
        begin
            ent(0, 0, k == 1 ? 5 : 0);
            ent(1, 10, 0);
            ent(2, k == 2 ? 32'h8000_0000 : (k == 0 ? 4 : 20), 0);
            wr(OFS_TBL_LEN, k == 3 ? 1 : 3);
            go(4'(k), ERR_DATA);
            chk(32'(cam_run), 32'h0);
            clr();
        end
    endtask : t_data
    task automatic t_start;
        logic [7:0] sa [3] = '{OFS_XFER, OFS_DIRSEL, OFS_SOFS_HI};
        logic [2:0] sc [3] = '{ERR_BUSY, ERR_DIRSEL, ERR_OFS};
        ent(0, 0, 0);
        ent(1, 100, 50);
        wr(OFS_TBL_LEN, 2);
        for (int k = 0; k < 3; k++)
        begin
            wr(sa[k], 1);
            go(4'(k + 9), sc[k]);
            wr(sa[k], 0);
            clr();
        end
    endtask : t_start
    task automatic t_tick;
        int n;
        n = 0;
        while (cyc_tick !== 1'h1)
            @(negedge ref_clk);
        @(negedge ref_clk);
        while (cyc_tick !== 1'h1 && n < 100)
        begin
            n++;
            @(negedge ref_clk);
        end
        chk(32'(n + 1), 32'd16);
    endtask : t_tick
    task automatic t_run;
        // Leftover start-time events would hide the first irq check
        wr(OFS_IRQ_ST, 32'h0000_003F);
        wr(OFS_IRQ_MSK, 32'h0000_003F);
        for (int k = 0; k < 4; k++)
        begin
            go(4'(k), ERR_NONE);
            chk(32'(cam_run), 32'h1);
            put(k, lim[k] - 1);
            repeat (40) @(negedge ref_clk);
            chk(32'(err_code), 32'h0);
            put(k, lim[k]);
            for (int i = 0; i < 100 && err_code === ERR_NONE; i++)
                @(negedge ref_clk);
            put(k, 64'h0);
            chk(32'(err_code), 32'(k == 3 ? ERR_SYNC : ERR_OVF));
            @(negedge ref_clk);
            chk(32'(irq), 32'h1);
            clr();
            wr(OFS_IRQ_ST, 32'h0000_003F);
            u_host.xfer(1'h0, OFS_IRQ_ST, 32'h0, q, e);
            chk(q, 32'h0);
            chk(32'(irq), 32'h0);
        end
        u_host.xfer(1'h0, 8'h30, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
    endtask : t_run
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    initial
    begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end
    // More than thirty times the expected run length
    initial
    begin
        #2000000;
        num_errors++;
        final_report();
    end
    initial
    begin
        rst_n = 1'h0;
        {mot_all_linear, mot_target_pls, mot_move_pls, mot_move_cmd, mot_gap_cmd} = '0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'h1;
        t_tick();
        t_data();
        t_start();
        t_run();
        final_report();
    end
endmodule : test_cam_operation_error_checker
